// >>> rbxcv_pkg.sv
// Purpose: shared constants and types of the registered bus transceiver
// Assumes: 32-bit APB data, byte offsets on aligned words
// Notes:   one storage path per direction, both built alike
package rbxcv_pkg;

  localparam int DATA_W    = 18;
  localparam int LOG_W     = DATA_W + 1;
  localparam int LOG_DEPTH = 32;
  localparam int APB_AW    = 8;
  localparam int CTL_W     = 8;
  localparam int SYNC_W    = CTL_W + 2 * DATA_W;

  // register offsets
  localparam logic [APB_AW-1:0] OFS_CTRL     = 8'h00;
  localparam logic [APB_AW-1:0] OFS_STATUS   = 8'h04;
  localparam logic [APB_AW-1:0] OFS_FWD_HELD = 8'h08;
  localparam logic [APB_AW-1:0] OFS_REV_HELD = 8'h0c;
  localparam logic [APB_AW-1:0] OFS_LOG      = 8'h10;

  // field positions
  localparam int CTRL_LOG_EN_BIT = 0;
  localparam int ST_OVF_BIT      = 0;
  localparam int ST_EMPTY_BIT    = 1;
  localparam int ST_FULL_BIT     = 2;
  localparam int ST_LEVEL_LSB    = 8;
  localparam int ST_FWD_MODE_LSB = 16;
  localparam int ST_REV_MODE_LSB = 20;
  localparam int LOG_DIR_BIT     = 18;
  localparam int LOG_VALID_BIT   = 31;

  // synchroniser lanes for the control pins
  localparam int CTL_FWD_OE_N  = 0;
  localparam int CTL_REV_OE_N  = 1;
  localparam int CTL_FWD_CE_N  = 2;
  localparam int CTL_REV_CE_N  = 3;
  localparam int CTL_FWD_LATCH = 4;
  localparam int CTL_REV_LATCH = 5;
  localparam int CTL_FWD_CLK   = 6;
  localparam int CTL_REV_CLK   = 7;

  // values after reset
  localparam logic [CTL_W-1:0]  CTL_RST  = 8'h0f;
  localparam logic [31:0]       CTRL_RST = 32'h0000_0001;
  localparam logic [DATA_W-1:0] DATA_RST = 18'h0_0000;

  typedef enum logic [3:0] {
    MODE_OFF     = 4'h1,
    MODE_TRANSP  = 4'h2,
    MODE_HOLD    = 4'h4,
    MODE_CLOCKED = 4'h8
  } rbxcv_mode_t;

  typedef enum logic [1:0] {
    APB_IDLE = 2'h1,
    APB_RESP = 2'h2
  } rbxcv_apb_st_t;

endpackage

// >>> rbxcv_stream_if.sv
// Purpose: valid/ready carrier between the top and its log fifo
// Assumes: one clock for both sides
// Notes:   level counts words held, output stage included
`timescale 1ns/100ps
interface rbxcv_stream_if #(
  parameter int W  = 19,
  parameter int LW = 6
);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  logic [LW-1:0] level;

  modport store (input in_valid, input in_data, input out_ready,
                 output in_ready, output out_valid, output out_data, output level);
  modport user  (output in_valid, output in_data, output out_ready,
                 input in_ready, input out_valid, input out_data, input level);
endinterface

// >>> rbxcv_fifo.sv
// Purpose: capture log fifo with registered read data
// Assumes: DEPTH is a power of two
// Notes:   holds DEPTH words plus one in the output stage
`timescale 1ns/100ps
module rbxcv_fifo #(
  parameter int W     = 19,
  parameter int DEPTH = 32
) (
  input  wire logic   clk_sys_i,
  input  wire logic   rst_n_i,
  input  wire logic   ce_i,
  rbxcv_stream_if.store s
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam int LW = $clog2(DEPTH + 2);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [CW-1:0] count_q;
  logic          out_valid_q;
  logic [W-1:0]  out_data_q;
  logic          push;
  logic          load;

  assign s.in_ready  = (count_q != CW'(DEPTH));
  assign push        = s.in_valid && s.in_ready;
  // refill the output stage when it is empty or being taken
  assign load        = (count_q != '0) && (!out_valid_q || s.out_ready);
  assign s.out_valid = out_valid_q;
  assign s.out_data  = out_data_q;
  assign s.level     = LW'(count_q) + LW'(out_valid_q);

  always_ff @(posedge clk_sys_i)
  begin
    if (ce_i && push)
    begin
      mem_q[wptr_q] <= s.in_data;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wptr_q      <= '0;
      rptr_q      <= '0;
      count_q     <= '0;
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
    end
    else if (ce_i)
    begin
      if (push)
      begin
        wptr_q <= wptr_q + AW'(1);
      end
      if (load)
      begin
        rptr_q     <= rptr_q + AW'(1);
        out_data_q <= mem_q[rptr_q];
      end
      count_q <= count_q + CW'(push) - CW'(load);
      if (load)
      begin
        out_valid_q <= 1'b1;
      end
      else if (s.out_ready)
      begin
        out_valid_q <= 1'b0;
      end
    end
  end
endmodule

// >>> rbxcv_top.sv
// Purpose: 18-bit registered bidirectional bus transceiver with apb view
// Assumes: pins come from outside the clock domain; 200 MHz clk_sys_i
// Notes:   pin behaviour is sampled, so data outputs trail inputs by four clocks, output enables by three
//
// Contract
// - eighteen data bits carried each way, every bit path identical
// - each direction: transparent, latched hold, or edge-clocked storage
// - output enable high floats that direction's outputs, low drives them
// - latch open: output follows input regardless of clock and clock enable
// - clock enable is active low; edges count only while it is low
// - latch closed, no qualifying edge: output keeps its previous level
// - closing latch with clock high holds only if clock rose first
// - reverse direction mirrors forward with its own four controls
// - backplane outputs open drain: pull low for zero, else release
// - card pins are forward inputs and three-state reverse outputs
`timescale 1ns/100ps
module rbxcv_top #(
  parameter int DATA_W    = rbxcv_pkg::DATA_W,
  parameter int LOG_DEPTH = rbxcv_pkg::LOG_DEPTH
) (
  input  wire logic                        clk_sys_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        ce_i,
  input  wire logic                        fwd_out_en_n_i,
  input  wire logic                        rev_out_en_n_i,
  input  wire logic                        fwd_clk_en_n_i,
  input  wire logic                        rev_clk_en_n_i,
  input  wire logic                        fwd_latch_open_i,
  input  wire logic                        rev_latch_open_i,
  input  wire logic                        fwd_capture_clk_i,
  input  wire logic                        rev_capture_clk_i,
  input  wire logic [DATA_W-1:0]           card_side_data_i,
  output logic      [DATA_W-1:0]           card_side_data_o,
  output logic      [DATA_W-1:0]           card_side_data_oe_o,
  input  wire logic [DATA_W-1:0]           backplane_side_data_i,
  output logic      [DATA_W-1:0]           backplane_side_data_o,
  output logic      [DATA_W-1:0]           backplane_side_data_oe_o,
  input  wire logic                        psel_i,
  input  wire logic                        penable_i,
  input  wire logic                        pwrite_i,
  input  wire logic [rbxcv_pkg::APB_AW-1:0] paddr_i,
  input  wire logic [31:0]                 pwdata_i,
  input  wire logic [3:0]                  pstrb_i,
  output logic      [31:0]                 prdata_o,
  output logic                             pready_o,
  output logic                             pslverr_o
);
  localparam int SW = rbxcv_pkg::CTL_W + 2 * DATA_W;
  localparam int LW = $clog2(LOG_DEPTH + 2);
  localparam int GW = DATA_W + 1;

  // one storage step: latch wins, then a qualified edge, else hold
  function automatic logic [DATA_W-1:0] next_store(
    input logic [DATA_W-1:0] held,
    input logic [DATA_W-1:0] din,
    input logic              latch_open,
    input logic              clk_en_n,
    input logic              clk_rise
  );
    logic [DATA_W-1:0] r;
    r = held;
    if (latch_open)
    begin
      r = din;
    end
    else if (!clk_en_n && clk_rise)
    begin
      r = din;
    end
    return r;
  endfunction

  function automatic rbxcv_pkg::rbxcv_mode_t mode_of(
    input logic oe_n,
    input logic latch_open,
    input logic clk_en_n
  );
    rbxcv_pkg::rbxcv_mode_t m;
    m = rbxcv_pkg::MODE_CLOCKED;
    if (oe_n)
    begin
      m = rbxcv_pkg::MODE_OFF;
    end
    else if (latch_open)
    begin
      m = rbxcv_pkg::MODE_TRANSP;
    end
    else if (clk_en_n)
    begin
      m = rbxcv_pkg::MODE_HOLD;
    end
    return m;
  endfunction

  // pin synchronisers
  logic [SW-1:0]     meta_q;
  logic [SW-1:0]     sync_q;
  logic [SW-1:0]     pins;
  // reset image: enables off, everything else low
  localparam logic [SW-1:0] SYNC_RST = {{(2 * DATA_W){1'b0}}, rbxcv_pkg::CTL_RST};
  logic              fwd_clk_prev_q;
  logic              rev_clk_prev_q;

  assign pins     = {backplane_side_data_i, card_side_data_i,
                     rev_capture_clk_i, fwd_capture_clk_i,
                     rev_latch_open_i, fwd_latch_open_i,
                     rev_clk_en_n_i, fwd_clk_en_n_i,
                     rev_out_en_n_i, fwd_out_en_n_i};

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= SYNC_RST;
      sync_q <= SYNC_RST;
    end
    else if (ce_i)
    begin
      meta_q <= pins;
      sync_q <= meta_q;
    end
  end

  logic              fwd_oe_n;
  logic              rev_oe_n;
  logic              fwd_ce_n;
  logic              rev_ce_n;
  logic              fwd_latch;
  logic              rev_latch;
  logic              fwd_clk;
  logic              rev_clk;
  logic [DATA_W-1:0] card_in;
  logic [DATA_W-1:0] bp_in;
  logic              fwd_rise;
  logic              rev_rise;

  assign fwd_oe_n  = sync_q[rbxcv_pkg::CTL_FWD_OE_N];
  assign rev_oe_n  = sync_q[rbxcv_pkg::CTL_REV_OE_N];
  assign fwd_ce_n  = sync_q[rbxcv_pkg::CTL_FWD_CE_N];
  assign rev_ce_n  = sync_q[rbxcv_pkg::CTL_REV_CE_N];
  assign fwd_latch = sync_q[rbxcv_pkg::CTL_FWD_LATCH];
  assign rev_latch = sync_q[rbxcv_pkg::CTL_REV_LATCH];
  assign fwd_clk   = sync_q[rbxcv_pkg::CTL_FWD_CLK];
  assign rev_clk   = sync_q[rbxcv_pkg::CTL_REV_CLK];
  assign card_in   = sync_q[rbxcv_pkg::CTL_W +: DATA_W];
  assign bp_in     = sync_q[rbxcv_pkg::CTL_W + DATA_W +: DATA_W];
  assign fwd_rise  = fwd_clk && !fwd_clk_prev_q;
  assign rev_rise  = rev_clk && !rev_clk_prev_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fwd_clk_prev_q <= 1'b0;
      rev_clk_prev_q <= 1'b0;
    end
    else if (ce_i)
    begin
      fwd_clk_prev_q <= fwd_clk;
      rev_clk_prev_q <= rev_clk;
    end
  end

  // storage, one register per direction
  logic [DATA_W-1:0] fwd_store_q;
  logic [DATA_W-1:0] rev_store_q;
  logic              fwd_cap;
  logic              rev_cap;

  assign fwd_cap = !fwd_latch && !fwd_ce_n && fwd_rise;
  assign rev_cap = !rev_latch && !rev_ce_n && rev_rise;

  // hold when latch closes after clock high: no edge seen
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fwd_store_q <= rbxcv_pkg::DATA_RST;
      rev_store_q <= rbxcv_pkg::DATA_RST;
    end
    else if (ce_i)
    begin
      fwd_store_q <= next_store(fwd_store_q, card_in, fwd_latch, fwd_ce_n, fwd_rise);
      rev_store_q <= next_store(rev_store_q, bp_in, rev_latch, rev_ce_n, rev_rise);
    end
  end

  // pin drivers
  logic [DATA_W-1:0] card_o_q;
  logic [DATA_W-1:0] card_oe_q;
  logic [DATA_W-1:0] bp_o_q;
  logic [DATA_W-1:0] bp_oe_q;

  // backplane open drain: enable only for zeros; card pins driven whole while rev_oe_n is low
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      card_o_q  <= '0;
      card_oe_q <= '0;
      bp_o_q    <= '0;
      bp_oe_q   <= '0;
    end
    else if (ce_i)
    begin
      card_o_q  <= rev_store_q;
      card_oe_q <= {DATA_W{!rev_oe_n}};
      bp_o_q    <= '0;
      bp_oe_q   <= {DATA_W{!fwd_oe_n}} & ~fwd_store_q;
    end
  end

  assign card_side_data_o         = card_o_q;
  assign card_side_data_oe_o      = card_oe_q;
  assign backplane_side_data_o    = bp_o_q;
  assign backplane_side_data_oe_o = bp_oe_q;

  // capture log: one word per cycle with a clocked capture, forward wins over reverse
  rbxcv_stream_if #(.W(GW), .LW(LW)) log_if ();

  rbxcv_fifo #(
    .W     (GW),
    .DEPTH (LOG_DEPTH)
  ) u_log (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .s         (log_if)
  );

  logic [31:0] ctrl_q;
  logic        ovf_q;
  logic        log_en;
  logic        want_push;
  logic        lost;

  assign log_en          = ctrl_q[rbxcv_pkg::CTRL_LOG_EN_BIT];
  assign want_push       = log_en && (fwd_cap || rev_cap);
  assign log_if.in_valid = want_push;
  assign log_if.in_data  = fwd_cap ? {1'b0, card_in} : {1'b1, bp_in};
  // a full log or a same-cycle reverse capture loses a word
  assign lost            = (want_push && !log_if.in_ready) || (log_en && fwd_cap && rev_cap);

  // apb slave: setup, then two access cycles
  rbxcv_pkg::rbxcv_apb_st_t apb_q;
  logic [31:0]              rdata_q;
  logic                     pready_q;
  logic                     pslverr_q;
  logic                     access;
  logic                     wr_done;
  logic                     rd_done;
  logic                     mapped;
  logic                     ovf_clr;
  logic [31:0]              status;
  logic [31:0]              rd_mux;

  assign access  = psel_i && penable_i && (apb_q == rbxcv_pkg::APB_IDLE);
  assign wr_done = access && pwrite_i;
  assign rd_done = access && !pwrite_i;
  assign mapped  = (paddr_i == rbxcv_pkg::OFS_CTRL)     ||
                   (paddr_i == rbxcv_pkg::OFS_STATUS)   ||
                   (paddr_i == rbxcv_pkg::OFS_FWD_HELD) ||
                   (paddr_i == rbxcv_pkg::OFS_REV_HELD) ||
                   (paddr_i == rbxcv_pkg::OFS_LOG);
  assign ovf_clr = wr_done && (paddr_i == rbxcv_pkg::OFS_STATUS) && pstrb_i[0] &&
                   pwdata_i[rbxcv_pkg::ST_OVF_BIT];
  assign log_if.out_ready = rd_done && (paddr_i == rbxcv_pkg::OFS_LOG);

  always_comb
  begin
    status = '0;
    status[rbxcv_pkg::ST_OVF_BIT]   = ovf_q;
    status[rbxcv_pkg::ST_EMPTY_BIT] = !log_if.out_valid;
    status[rbxcv_pkg::ST_FULL_BIT]  = !log_if.in_ready;
    status[rbxcv_pkg::ST_LEVEL_LSB +: LW] = log_if.level;
    status[rbxcv_pkg::ST_FWD_MODE_LSB +: 4] = mode_of(fwd_oe_n, fwd_latch, fwd_ce_n);
    status[rbxcv_pkg::ST_REV_MODE_LSB +: 4] = mode_of(rev_oe_n, rev_latch, rev_ce_n);
  end

  always_comb
  begin
    rd_mux = '0;
    unique case (paddr_i)
      rbxcv_pkg::OFS_CTRL:     rd_mux = ctrl_q;
      rbxcv_pkg::OFS_STATUS:   rd_mux = status;
      rbxcv_pkg::OFS_FWD_HELD: rd_mux[DATA_W-1:0] = fwd_store_q;
      rbxcv_pkg::OFS_REV_HELD: rd_mux[DATA_W-1:0] = rev_store_q;
      rbxcv_pkg::OFS_LOG:
      begin
        rd_mux[GW-1:0] = log_if.out_data;
        rd_mux[rbxcv_pkg::LOG_VALID_BIT] = log_if.out_valid;
      end
      default:                 rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      apb_q     <= rbxcv_pkg::APB_IDLE;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      rdata_q   <= '0;
    end
    else if (ce_i)
    begin
      unique case (apb_q)
        rbxcv_pkg::APB_IDLE:
        begin
          if (access)
          begin
            apb_q     <= rbxcv_pkg::APB_RESP;
            pready_q  <= 1'b1;
            pslverr_q <= !mapped;
            rdata_q   <= pwrite_i ? 32'h0000_0000 : rd_mux;
          end
        end
        rbxcv_pkg::APB_RESP:
        begin
          apb_q     <= rbxcv_pkg::APB_IDLE;
          pready_q  <= 1'b0;
          pslverr_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_q <= rbxcv_pkg::CTRL_RST;
    end
    else if (ce_i && wr_done && (paddr_i == rbxcv_pkg::OFS_CTRL) && pstrb_i[0])
    begin
      ctrl_q[7:0] <= pwdata_i[7:0];
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ovf_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (lost)
      begin
        ovf_q <= 1'b1;
      end
      else if (ovf_clr)
      begin
        ovf_q <= 1'b0;
      end
    end
  end

  assign prdata_o  = rdata_q;
  assign pready_o  = pready_q;
  assign pslverr_o = pslverr_q;
endmodule

// >>> rbxcv_props.sv
// Purpose: port-level checks of the registered transceiver
// Assumes: pin latencies of four clocks for data and three for output enables, apb answer one cycle after access
// Notes:   bound to the top from the bench
`timescale 1ns/100ps
module rbxcv_props #(
  parameter int DATA_W = 18
) (
  input wire logic              clk_sys_i,
  input wire logic              rst_n_i,
  input wire logic              ce_i,
  input wire logic              fwd_out_en_n_i,
  input wire logic              rev_out_en_n_i,
  input wire logic              fwd_clk_en_n_i,
  input wire logic              rev_clk_en_n_i,
  input wire logic              fwd_latch_open_i,
  input wire logic              rev_latch_open_i,
  input wire logic              fwd_capture_clk_i,
  input wire logic [DATA_W-1:0] card_side_data_i,
  input wire logic [DATA_W-1:0] card_side_data_o,
  input wire logic [DATA_W-1:0] card_side_data_oe_o,
  input wire logic [DATA_W-1:0] backplane_side_data_i,
  input wire logic [DATA_W-1:0] backplane_side_data_o,
  input wire logic [DATA_W-1:0] backplane_side_data_oe_o,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pready_o,
  input wire logic              pslverr_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  a_fwd_float: assert property ((ce_i && fwd_out_en_n_i) [*4]
    |-> backplane_side_data_oe_o == '0) else $error("forward pins driven while off");
  a_rev_float: assert property ((ce_i && rev_out_en_n_i) [*4]
    |-> card_side_data_oe_o == '0) else $error("card pins driven while off");
  a_rev_drives: assert property ((ce_i && !rev_out_en_n_i) [*4]
    |-> &card_side_data_oe_o) else $error("card pins not driven while on");
  a_bp_open_drain: assert property (backplane_side_data_o == '0)
    else $error("backplane pin driven high");
  a_fwd_transp: assert property ((ce_i && fwd_latch_open_i && !fwd_out_en_n_i
    && $stable(card_side_data_i)) [*6] |-> backplane_side_data_oe_o == ~card_side_data_i)
    else $error("forward output not following input");
  a_rev_transp: assert property ((ce_i && rev_latch_open_i
    && $stable(backplane_side_data_i)) [*6] |-> card_side_data_o == backplane_side_data_i)
    else $error("reverse output not following input");
  a_fwd_hold: assert property ((ce_i && !fwd_latch_open_i && fwd_clk_en_n_i
    && !fwd_out_en_n_i) [*8] |-> $stable(backplane_side_data_oe_o))
    else $error("forward output moved while inhibited");
  a_rev_inhibit: assert property ((ce_i && !rev_latch_open_i && rev_clk_en_n_i) [*8]
    |-> $stable(card_side_data_o)) else $error("reverse storage moved while inhibited");
  a_apb_answer: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("apb access not answered");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  a_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");

  c_transp: cover property (fwd_latch_open_i && !fwd_out_en_n_i);
  c_capture: cover property ($rose(fwd_capture_clk_i) && !fwd_clk_en_n_i);
  c_err: cover property (pslverr_o);
endmodule

// >>> rbxcv_far_model.sv
// Purpose: card logic and backplane agents around the transceiver
// Assumes: pull-up on every backplane line
// Notes:   resolves both pin sets from all their drivers
`timescale 1ns/100ps
module rbxcv_far_model #(
  parameter int DATA_W = 18
) (
  input  wire logic [DATA_W-1:0] card_drive_i,
  input  wire logic [DATA_W-1:0] agent_pull_i,
  input  wire logic [DATA_W-1:0] dut_card_i,
  input  wire logic [DATA_W-1:0] dut_card_oe_i,
  input  wire logic [DATA_W-1:0] dut_bp_i,
  input  wire logic [DATA_W-1:0] dut_bp_oe_i,
  output logic      [DATA_W-1:0] card_line_o,
  output logic      [DATA_W-1:0] bp_line_o
);
  assign card_line_o = (dut_card_oe_i & dut_card_i) | (~dut_card_oe_i & card_drive_i);
  assign bp_line_o = ~(agent_pull_i | (dut_bp_oe_i & ~dut_bp_i));
endmodule

// >>> registered_bidir_bus_transceiver_tb_top.sv
// Purpose: self-checking bench of the registered transceiver
// Assumes: index 0 is forward, 1 is reverse in control vectors
// Notes:   log disabled before latch-close case, edge there is unknown
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module registered_bidir_bus_transceiver_tb_top;
  logic        clk_sys_i;
  logic        rst_n_i = 1'h0;
  logic [1:0]  oe_n = 2'h3;
  logic [1:0]  ce_n = 2'h3;
  logic [1:0]  le = 2'h0;
  logic [1:0]  ck = 2'h0;
  logic [17:0] card_drive = 18'h0;
  logic [17:0] agent_pull = 18'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [17:0] card_line, bp_line, card_side_data_o, card_side_data_oe_o;
  logic [17:0] backplane_side_data_o, backplane_side_data_oe_o;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o;
  int          errors = 0;
  int          checks = 0;

  rbxcv_top u_dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(1'h1),
    .fwd_out_en_n_i(oe_n[0]), .rev_out_en_n_i(oe_n[1]),
    .fwd_clk_en_n_i(ce_n[0]), .rev_clk_en_n_i(ce_n[1]),
    .fwd_latch_open_i(le[0]), .rev_latch_open_i(le[1]),
    .fwd_capture_clk_i(ck[0]), .rev_capture_clk_i(ck[1]),
    .card_side_data_i(card_line), .card_side_data_o(card_side_data_o),
    .card_side_data_oe_o(card_side_data_oe_o), .backplane_side_data_i(bp_line),
    .backplane_side_data_o(backplane_side_data_o),
    .backplane_side_data_oe_o(backplane_side_data_oe_o),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o));
  rbxcv_far_model u_far (
    .card_drive_i(card_drive), .agent_pull_i(agent_pull), .dut_card_i(card_side_data_o),
    .dut_card_oe_i(card_side_data_oe_o), .dut_bp_i(backplane_side_data_o),
    .dut_bp_oe_i(backplane_side_data_oe_o), .card_line_o(card_line), .bp_line_o(bp_line));

  initial
  begin
    clk_sys_i = 1'h0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic put(input int d, input logic [17:0] v);
    if (d == 0)
      card_drive <= v;
    else
      agent_pull <= ~v;
  endtask
  function automatic logic [17:0] outv(input int d);
    return d == 0 ? bp_line : card_side_data_o;
  endfunction
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge clk_sys_i);
    psel   <= 1'h1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk_sys_i);
    penable <= 1'h1;
    do @(posedge clk_sys_i); while (pready_o !== 1'h1);
    rd = prdata_o;
    er = pslverr_o;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] rd;
    logic        er;
    apb(1'h0, a, 32'h0, rd, er);
    `CHK(rd & m, exp)
  endtask
  // capture edge with data steady around it
  task automatic cap(input int d, input logic [17:0] v);
    put(d, v);
    cyc(4);
    ck[d] <= 1'h1;
    cyc(4);
    ck[d] <= 1'h0;
    cyc(4);
  endtask

  task automatic t_regs();
    logic [31:0] rd;
    logic        er;
    rdchk(rbxcv_pkg::OFS_CTRL, rbxcv_pkg::CTRL_RST, '1);
    rdchk(rbxcv_pkg::OFS_STATUS, 32'h2, 32'h3f07);
    apb(1'h1, rbxcv_pkg::OFS_CTRL, 32'h0, rd, er);
    rdchk(rbxcv_pkg::OFS_CTRL, 32'h0, '1);
    apb(1'h1, rbxcv_pkg::OFS_CTRL, 32'h1, rd, er);
    apb(1'h0, 8'h20, 32'h0, rd, er);
    `CHK({er, rd}, 33'h1_0000_0000)
    apb(1'h1, rbxcv_pkg::OFS_FWD_HELD, 32'h3, rd, er);
    rdchk(rbxcv_pkg::OFS_FWD_HELD, 32'h0, '1);
  endtask
  task automatic t_transp(input int d);
    logic [17:0] pat [4];
    pat = '{18'h2aaaa, 18'h15555, 18'h3ffff, 18'h00001};
    oe_n[1-d] <= 1'h1;
    oe_n[d]   <= 1'h0;
    le[d]     <= 1'h1;
    // let the other direction release the shared lines first
    cyc(6);
    foreach (pat[i])
    begin
      put(d, pat[i]);
      ck[d] <= ~ck[d];
      cyc(6);
      `CHK(outv(d), pat[i])
    end
    if (d == 1)
      `CHK(card_side_data_oe_o, 18'h3ffff)
  endtask
  task automatic t_clocked(input int d);
    le[d]   <= 1'h0;
    ce_n[d] <= 1'h0;
    cap(d, 18'h25a5a);
    put(d, 18'h1a5a5);
    cyc(6);
    `CHK(outv(d), 18'h25a5a)
    ce_n[d] <= 1'h1;
    cap(d, 18'h00f0f);
    `CHK(outv(d), 18'h25a5a)
    rdchk(d ? rbxcv_pkg::OFS_REV_HELD : rbxcv_pkg::OFS_FWD_HELD, 32'h25a5a, '1);
    oe_n[d] <= 1'h1;
    ce_n[d] <= 1'h0;
    cap(d, 18'h3c3c3);
    `CHK(d ? card_side_data_oe_o : bp_line, d ? 18'h0 : 18'h3ffff)
    oe_n[d] <= 1'h0;
    cyc(6);
    `CHK(outv(d), 18'h3c3c3)
  endtask
  task automatic t_fifo();
    logic [31:0] rd;
    logic        er;
    // card logic drives the card lines again, agents let go
    agent_pull <= 18'h0;
    oe_n       <= 2'h2;
    for (int i = 0; i < 4; i++)
      rdchk(rbxcv_pkg::OFS_LOG, {1'h1, 12'h0, i[1], i[0] ? 18'h3c3c3 : 18'h25a5a}, '1);
    for (int i = 1; i <= 34; i++)
    begin
      cap(0, 18'(i));
      if (i == 33)
        rdchk(rbxcv_pkg::OFS_STATUS, 32'h2104, 32'h3f07);
    end
    rdchk(rbxcv_pkg::OFS_STATUS, 32'h2105, 32'h3f07);
    apb(1'h1, rbxcv_pkg::OFS_STATUS, 32'h1, rd, er);
    rdchk(rbxcv_pkg::OFS_STATUS, 32'h2104, 32'h3f07);
    for (int i = 1; i <= 33; i++)
      rdchk(rbxcv_pkg::OFS_LOG, 32'h8000_0000 | i, '1);
    rdchk(rbxcv_pkg::OFS_STATUS, 32'h2, 32'h3f07);
    rdchk(rbxcv_pkg::OFS_LOG, 32'h0, 32'h8000_0000);
  endtask
  task automatic t_close();
    logic [31:0] rd;
    logic        er;
    apb(1'h1, rbxcv_pkg::OFS_CTRL, 32'h0, rd, er);
    le[0] <= 1'h1;
    put(0, 18'h12345);
    cyc(6);
    ck[0] <= 1'h1;
    cyc(4);
    le[0] <= 1'h0;
    cyc(4);
    put(0, 18'h0abcd);
    cyc(6);
    `CHK(bp_line, 18'h12345)
    ck[0] <= 1'h0;
    cyc(6);
    `CHK(bp_line, 18'h12345)
    rdchk(rbxcv_pkg::OFS_STATUS, 32'h0018_0002, 32'h00ff_0007);
  endtask

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    cyc(5);
    rst_n_i <= 1'h1;
    cyc(4);
    t_regs();
    for (int d = 0; d < 2; d++)
    begin
      t_transp(d);
      t_clocked(d);
    end
    t_fifo();
    t_close();
    end_of_test();
  end

  // generous: the sequence needs well under 5000 cycles
  initial
  begin
    cyc(20000);
    errors++;
    end_of_test();
  end
endmodule

bind rbxcv_top rbxcv_props #(.DATA_W(DATA_W)) u_props (.*);
